// ==== key_deglitch.sv ====
// Symmetric deglitch filter: output follows input after a stable run
`timescale 1ns/10ps
module key_deglitch #(
    parameter int unsigned W     = 28,
    parameter int unsigned LIMIT = 640_000
) (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_clk_en,
    // Level in and filtered level out
    input  wire logic i_din,
    output logic      o_level
);
    logic [W-1:0] cnt_ff;
    logic         level_ff;

    // Any bounce back to the current level restarts the count
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            cnt_ff   <= '0;
            level_ff <= 1'b0;
        end else if (i_clk_en) begin
            if (i_din == level_ff) begin
                cnt_ff <= '0;
            end else if (cnt_ff == W'(LIMIT - 1)) begin
                cnt_ff   <= '0;
                level_ff <= i_din;
            end else begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

    assign o_level = level_ff;
endmodule : key_deglitch

// ==== key_power_latch_sequencer.sv ====
// Power-up/down sequencer with power latch and secure engine shutoff
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/10ps
// Functional notes
// - Filtered key high starts the system; main relay drive switches on first.
// - Key input deglitched both ways by the key filter time, typically 16 ms.
// - Switched supply: biasing starts once battery is not undervoltage after relay.
// - Five-volt regulator after regulator delay; sensor supplies together with it.
// - Three-volt regulator about 1.0 ms after five-volt supply is good.
// - Permanent supply: bias on raw key rise; regulator delay after filter.
// - Global enable combines latch, timeout, key and battery; the sequencer past relay, the key-on timers and the driver gating use it.
// - Key low with latch hold bit set switches off after filter time.
// - Latch hold bit low keeps system on; host ends latch writing it high.
// - Latch timeout, chosen by a 3-bit field, forces shutdown.
// - Status shows raw key and filtered key.
// - Regulator hold bit, reset 0, picks whether regulators stop with relay.
// - With hold bit set only relay stops; regulators run until battery UV.
// - Without latch or shutoff mode, key fall cuts injectors and starters.
// - Shutoff mode: starters cut after hold delay only if key still low.
// - Hold delay granted only after 225 ms / 600 ms key-on with drivers active.
// - Hold delay withheld if watchdog error count reached 4 during key-on.
// - Secure shutoff touches only injector and starter drivers.
// - Key fall starts a host-independent 225 ms timer that cuts those stages.
// - Host driver writes still act during hold; config six enables shutoff.
// - After a shutoff event, key must be on 600 ms before another hold.
module key_power_latch_sequencer
    import key_power_pkg::*;
#(
    parameter int unsigned KEY_FILTER = KEY_FILTER_CYC,
    parameter int unsigned REG_DELAY  = REG_DELAY_CYC,
    parameter int unsigned V3_DELAY   = V3_DELAY_CYC,
    parameter int unsigned SEO_HOLD   = SEO_HOLD_CYC,
    parameter int unsigned INJ_QUAL   = INJ_QUAL_CYC,
    parameter int unsigned ST_QUAL    = ST_QUAL_CYC,
    parameter int unsigned LATCH_STEP = LATCH_STEP_CYC
) (
    // Clock, reset, enable
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_sys_rst,
    input  wire logic                        i_clk_en,
    // Register bus
    input  wire key_power_pkg::apb_req_type  i_apb,
    output key_power_pkg::apb_rsp_type       o_apb,
    // Pins and analog monitors
    input  wire logic                        i_key_raw,
    input  wire logic                        i_battery_not_undervolt,
    input  wire logic                        i_five_volt_ok,
    input  wire logic                        i_permanent_supply,
    // Watchdog error count, same clock
    input  wire logic [2:0]                  i_watchdog_error_count,
    // Supply and driver enables
    output key_power_pkg::supply_en_type     o_supply,
    output logic [3:0]                       o_injector_stages,
    output logic [1:0]                       o_starter_drivers,
    output logic                             o_power_down_rst
);
    import key_power_pkg::*;

    // Pin synchronisers
    logic [3:0] pin_meta_ff;
    logic [3:0] pin_sync_ff;
    logic [3:0] pin_raw;
    assign pin_raw = {i_permanent_supply, i_five_volt_ok, i_battery_not_undervolt, i_key_raw};

    generate
        for (genvar g = 0; g < 4; g++) begin : g_sync
            always_ff @(posedge i_sys_clk) begin
                if (i_sys_rst) begin
                    pin_meta_ff[g] <= 1'b0;
                    pin_sync_ff[g] <= 1'b0;
                end else if (i_clk_en) begin
                    pin_meta_ff[g] <= pin_raw[g];
                    pin_sync_ff[g] <= pin_meta_ff[g];
                end
            end
        end
    endgenerate

    logic key_sync;
    logic battery_not_undervolt;
    logic five_ok;
    logic permanent;
    assign key_sync              = pin_sync_ff[0];
    assign battery_not_undervolt = pin_sync_ff[1];
    assign five_ok               = pin_sync_ff[2];
    assign permanent             = pin_sync_ff[3];

    // Registers
    logic       latch_hold_n_ff;
    logic       regulator_hold_sel_ff;
    logic [2:0] latch_timeout_cfg_ff;
    logic       seo_en_ff;
    logic [3:0] drv_inj_ff;
    logic [1:0] drv_st_ff;

    // Key filter
    logic key_flt;
    key_deglitch #(.W(TMR_W), .LIMIT(KEY_FILTER)) u_key_flt (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_clk_en  (i_clk_en),
        .i_din     (key_sync),
        .o_level   (key_flt)
    );

    seq_state_type state_ff;
    seq_state_type nxt_state;

    // Latch timeout, zero configuration disables it
    function automatic logic [TMR_W-1:0] timeout_cycles(input logic [2:0] cfg);
        timeout_cycles = TMR_W'(cfg) * TMR_W'(LATCH_STEP);
    endfunction : timeout_cycles

    logic latch_to_done;
    logic latch_timeout_not_expired;
    sat_timer #(.W(TMR_W)) u_latch_to (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_clk_en  (i_clk_en),
        .i_clear   (latch_hold_n_ff || key_flt || state_ff == ST_OFF),
        .i_run     (1'b1),
        .i_limit   (timeout_cycles(latch_timeout_cfg_ff)),
        .o_done    (latch_to_done)
    );
    assign latch_timeout_not_expired = !(latch_to_done && latch_timeout_cfg_ff != 3'h0);

    logic global_enable;
    assign global_enable = ((!latch_hold_n_ff && latch_timeout_not_expired) || key_flt)
                           && battery_not_undervolt;

    // Regulator delay and three-volt delay
    logic reg_done;
    logic v3_done;
    sat_timer #(.W(TMR_W)) u_reg_dly (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_clk_en  (i_clk_en),
        .i_clear   (state_ff != ST_BIAS),
        .i_run     (1'b1),
        .i_limit   (TMR_W'(REG_DELAY)),
        .o_done    (reg_done)
    );
    sat_timer #(.W(TMR_W)) u_v3_dly (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_clk_en  (i_clk_en),
        .i_clear   (!(state_ff == ST_REG5 && five_ok)),
        .i_run     (1'b1),
        .i_limit   (TMR_W'(V3_DELAY)),
        .o_done    (v3_done)
    );

    // Sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_OFF: begin
                if (key_flt) begin
                    nxt_state = ST_RELAY;
                end
            end
            ST_RELAY: begin
                // Battery UV is expected here until the relay closes
                if (!key_flt) begin
                    nxt_state = ST_OFF;
                end else if (battery_not_undervolt) begin
                    nxt_state = ST_BIAS;
                end
            end
            ST_BIAS: begin
                if (!global_enable) begin
                    nxt_state = ST_OFF;
                end else if (reg_done) begin
                    nxt_state = ST_REG5;
                end
            end
            ST_REG5: begin
                if (!global_enable) begin
                    nxt_state = ST_OFF;
                end else if (v3_done) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!global_enable) begin
                    nxt_state = regulator_hold_sel_ff ? ST_HOLD : ST_OFF;
                end
            end
            ST_HOLD: begin
                if (!battery_not_undervolt || !regulator_hold_sel_ff) begin
                    nxt_state = ST_OFF;
                end else if (global_enable) begin
                    nxt_state = ST_RUN;
                end
            end
            default: nxt_state = ST_OFF;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            state_ff <= ST_OFF;
        end else if (i_clk_en) begin
            state_ff <= nxt_state;
        end
    end

    // Supply enables, registered from the next state
    function automatic supply_en_type supply_of(input seq_state_type st, input logic early_bias);
        supply_of                   = '0;
        supply_of.main_relay_drive  = (st != ST_OFF && st != ST_HOLD);
        supply_of.bias              = (st != ST_OFF && st != ST_RELAY) || early_bias;
        supply_of.five_volt_supply  = (st == ST_REG5 || st == ST_RUN || st == ST_HOLD);
        supply_of.sensor_supplies   = supply_of.five_volt_supply;
        supply_of.three_volt_supply = (st == ST_RUN || st == ST_HOLD);
    endfunction : supply_of

    supply_en_type supply_ff;
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            supply_ff <= '0;
        end else if (i_clk_en) begin
            supply_ff <= supply_of(nxt_state, permanent && key_sync);
        end
    end
    assign o_supply = supply_ff;

    // Reset request stays released in hold until the five-volt supply fails
    logic power_down_rst_ff;
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            power_down_rst_ff <= 1'b1;
        end else if (i_clk_en) begin
            power_down_rst_ff <= (nxt_state == ST_OFF) || (nxt_state == ST_HOLD && !five_ok);
        end
    end
    assign o_power_down_rst = power_down_rst_ff;

    // Secure shutoff hold timer runs only while the key is low
    logic seo_done;
    sat_timer #(.W(TMR_W)) u_seo (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_clk_en  (i_clk_en),
        .i_clear   (key_flt),
        .i_run     (seo_en_ff && state_ff != ST_OFF),
        .i_limit   (TMR_W'(SEO_HOLD)),
        .o_done    (seo_done)
    );

    // Key-on qualification per driver group: 0 injectors, 1 starters
    logic [1:0] qual_done;
    logic [1:0] grp_active;
    logic [TMR_W-1:0] qual_lim [2];
    logic wd_fault;
    assign grp_active  = {|drv_st_ff, |drv_inj_ff};
    assign qual_lim[0] = TMR_W'(INJ_QUAL);
    assign qual_lim[1] = TMR_W'(ST_QUAL);
    assign wd_fault    = (i_watchdog_error_count >= WD_ERR_LIMIT);

    generate
        for (genvar q = 0; q < 2; q++) begin : g_qual
            sat_timer #(.W(TMR_W)) u_qual (
                .i_sys_clk (i_sys_clk),
                .i_sys_rst (i_sys_rst),
                .i_clk_en  (i_clk_en),
                .i_clear   (state_ff == ST_OFF || (key_flt && wd_fault) || seo_done),
                .i_run     (key_flt && grp_active[q] && global_enable),
                .i_limit   (qual_lim[q]),
                .o_done    (qual_done[q])
            );
        end
    endgenerate

    // After an event the injectors also wait for the longer key-on time
    logic seo_event_ff;
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            seo_event_ff <= 1'b0;
        end else if (i_clk_en) begin
            if (seo_done) begin
                seo_event_ff <= 1'b1;
            end else if (qual_done[1] && key_flt) begin
                seo_event_ff <= 1'b0;
            end
        end
    end

    logic inj_grant;
    logic st_grant;
    logic inj_allow;
    logic st_allow;
    logic latch_on;
    assign inj_grant = qual_done[0] && (!seo_event_ff || qual_done[1]);
    assign st_grant  = qual_done[1];
    assign latch_on  = !latch_hold_n_ff && !seo_en_ff;
    assign inj_allow = key_flt || latch_on || (seo_en_ff && inj_grant && !seo_done);
    assign st_allow  = key_flt || latch_on || (seo_en_ff && st_grant && !seo_done);

    // Only the injector and starter enables are gated by the shutoff path
    logic [3:0] inj_ff;
    logic [1:0] st_ff;
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            inj_ff <= '0;
            st_ff  <= '0;
        end else if (i_clk_en) begin
            inj_ff <= drv_inj_ff & {4{inj_allow && global_enable}};
            st_ff  <= drv_st_ff & {2{st_allow && global_enable}};
        end
    end
    assign o_injector_stages = inj_ff;
    assign o_starter_drivers = st_ff;

    // APB slave: zero wait states, read data latched in the setup phase
    logic        setup;
    logic        access;
    logic        hit;
    logic [31:0] status_word;
    logic [31:0] rd_word;
    logic [31:0] prdata_ff;
    logic        pslverr_ff;
    assign setup  = i_apb.psel && !i_apb.penable;
    assign access = i_apb.psel && i_apb.penable;
    assign hit    = (i_apb.paddr == CTRL_OFS) || (i_apb.paddr == CFG6_OFS)
                 || (i_apb.paddr == DRV_OFS) || (i_apb.paddr == STATUS_OFS);

    assign status_word = {21'h0, state_ff, 1'b0, st_grant, inj_grant, seo_en_ff && !key_flt && !seo_done,
                          !latch_timeout_not_expired, global_enable, key_flt, key_sync};

    always_comb begin
        case (i_apb.paddr)
            CTRL_OFS:   rd_word = {27'h0, latch_timeout_cfg_ff, regulator_hold_sel_ff, latch_hold_n_ff};
            CFG6_OFS:   rd_word = {31'h0, seo_en_ff};
            DRV_OFS:    rd_word = {26'h0, drv_st_ff, drv_inj_ff};
            STATUS_OFS: rd_word = status_word;
            default:    rd_word = 32'h0;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            prdata_ff  <= 32'h0;
            pslverr_ff <= 1'b0;
        end else if (i_clk_en && setup) begin
            prdata_ff  <= i_apb.pwrite ? 32'h0 : rd_word;
            pslverr_ff <= !hit;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            {latch_timeout_cfg_ff, regulator_hold_sel_ff, latch_hold_n_ff} <= CTRL_RST;
            seo_en_ff                                                    <= CFG6_RST;
            {drv_st_ff, drv_inj_ff}                                      <= DRV_RST;
        end else if (i_clk_en && access && i_apb.pwrite) begin
            case (i_apb.paddr)
                CTRL_OFS: begin
                    latch_hold_n_ff       <= i_apb.pwdata[CTRL_LATCH_BIT];
                    regulator_hold_sel_ff <= i_apb.pwdata[CTRL_HOLD_BIT];
                    latch_timeout_cfg_ff  <= i_apb.pwdata[CTRL_TO_LSB +: 3];
                end
                CFG6_OFS: seo_en_ff <= i_apb.pwdata[CFG6_SEO_BIT];
                DRV_OFS: begin
                    drv_inj_ff <= i_apb.pwdata[DRV_INJ_LSB +: 4];
                    drv_st_ff  <= i_apb.pwdata[DRV_ST_LSB +: 2];
                end
                default: ;
            endcase
        end
    end

    assign o_apb.prdata  = prdata_ff;
    assign o_apb.pready  = 1'b1;
    assign o_apb.pslverr = access && pslverr_ff;

    // Checks
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst || !i_clk_en);

    sequence s_key_start;
        state_ff == ST_OFF && key_flt;
    endsequence

    a_relay_first: assert property (s_key_start |=> o_supply.main_relay_drive && !o_supply.five_volt_supply)
        else $error("relay not first at key start");
    a_bias_battery: assert property ($rose(o_supply.bias) && !permanent |-> $past(battery_not_undervolt))
        else $error("bias before battery good");
    a_sensor_with_five: assert property ($rose(o_supply.five_volt_supply) |-> $rose(o_supply.sensor_supplies))
        else $error("sensor supplies not with five volt");
    a_three_after_five: assert property ($rose(o_supply.three_volt_supply) |-> $past(five_ok, 2))
        else $error("three volt before five volt good");
    a_enable_off: assert property (state_ff == ST_RUN && !global_enable |=> state_ff != ST_RUN)
        else $error("run kept without global enable");
    a_latch_keeps: assert property (state_ff == ST_RUN && global_enable && !latch_hold_n_ff |=> state_ff == ST_RUN)
        else $error("latched system left run");
    a_hold_regs: assert property (state_ff == ST_RUN && !global_enable && regulator_hold_sel_ff
                                  |=> !o_supply.main_relay_drive && o_supply.five_volt_supply)
        else $error("hold did not keep regulators");
    a_plain_off: assert property (state_ff == ST_RUN && !global_enable && !regulator_hold_sel_ff
                                  |=> !o_supply.main_relay_drive && !o_supply.three_volt_supply)
        else $error("regulators not off with relay");
    a_direct_cut: assert property ($fell(key_flt) && !seo_en_ff && latch_hold_n_ff
                                   |=> o_injector_stages == 4'h0 && o_starter_drivers == 2'h0)
        else $error("drivers not cut at key fall");
    a_seo_cut: assert property (seo_done && seo_en_ff && !key_flt |=> o_starter_drivers == 2'h0)
        else $error("starters kept after hold");
endmodule : key_power_latch_sequencer

// ==== key_power_latch_sequencer_test.sv ====
// Bench for the key power latch sequencer
`timescale 1ns/10ps
module key_power_latch_sequencer_test;
    import key_power_pkg::*;
    // Shortened timing so a full power cycle takes a few dozen clocks
    localparam int unsigned KF = 16, RG = 8, V3 = 8, SH = 40, IQ = 20, SQ = 50, LS = 10;
    logic i_sys_clk = 0, i_sys_rst = 1, key = 0, stuck = 0, clk_en = 1, perm = 0, wdf = 0, pdr, bat, fiv;
    logic [2:0] wd = 0;
    logic [15:0] lf = 16'hf715;
    apb_req_type req = '0;
    apb_rsp_type rsp;
    supply_en_type sup;
    logic [3:0] inj;
    logic [1:0] st;
    logic [32:0] q[$];
    int error_cnt = 0, checks = 0;
    always #12.5 i_sys_clk = ~i_sys_clk;
    function automatic logic [15:0] lfn(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfn
    // Error count stays below four unless the fault flag raises its top bit
    always @(posedge i_sys_clk) begin
        lf <= lfn(lf);
        wd <= {wdf, lf[1:0]};
    end
    key_power_latch_sequencer #(.KEY_FILTER(KF), .REG_DELAY(RG), .V3_DELAY(V3), .SEO_HOLD(SH),
        .INJ_QUAL(IQ), .ST_QUAL(SQ), .LATCH_STEP(LS)) dut (.i_sys_clk, .i_sys_rst, .i_clk_en(clk_en),
        .i_apb(req), .o_apb(rsp), .i_key_raw(key), .i_battery_not_undervolt(bat), .i_five_volt_ok(fiv),
        .i_permanent_supply(perm), .i_watchdog_error_count(wd), .o_supply(sup),
        .o_injector_stages(inj), .o_starter_drivers(st), .o_power_down_rst(pdr));
    supply_model model (.i_sys_clk, .i_relay(sup.main_relay_drive), .i_five_en(sup.five_volt_supply),
        .i_stuck(stuck), .o_batt_ok(bat), .o_five_ok(fiv));
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : tick
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        req <= '{1'b1, 1'b0, wr, a, d};
        tick(1);
        req.penable <= 1'b1;
        do tick(1); while (rsp.pready !== 1'b1);
        req <= '0;
        tick(1);
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd
    always @(posedge i_sys_clk)
        if (req.psel && req.penable && !req.pwrite && q.size() > 0)
            chk({rsp.pslverr, rsp.prdata}, q.pop_front());
    task automatic sup_is(input logic [4:0] e);
        for (int n = 0; n < 300 && sup !== e; n++) tick(1);
        chk({28'h0, sup}, {28'h0, e});
    endtask : sup_is
    task automatic pwr_up;
        key <= 1'b1;
        tick(KF);
        chk({28'h0, sup}, 33'h0);
        sup_is(5'h10);
        sup_is(5'h18);
        sup_is(5'h1e);
        sup_is(5'h1f);
    endtask : pwr_up
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        tick(8);
        i_sys_rst <= 1'b0;
        tick(1);
        chk({27'h0, sup, pdr}, 33'h1);
        rd(CTRL_OFS, {28'h0, CTRL_RST});
        rd(STATUS_OFS, 33'h0);
        rd(8'h10, {1'b1, 32'h0});
        pwr_up();
        rd(STATUS_OFS, 33'h607);
        bus(1'b1, DRV_OFS, 32'h3f);
        tick(1);
        chk({27'h0, st, inj}, 33'h3f);
        // Enable low freezes the filter, so the key release waits for it
        clk_en <= 1'b0;
        key <= 1'b0;
        tick(40);
        chk({28'h0, sup}, 33'h1f);
        clk_en <= 1'b1;
        sup_is(5'h0);
        chk({26'h0, st, inj, pdr}, 33'h1);
        $display("plain cycle done");
        pwr_up();
        bus(1'b1, CTRL_OFS, 32'h0);
        key <= 1'b0;
        tick(60);
        chk({28'h0, sup}, 33'h1f);
        bus(1'b1, CTRL_OFS, 32'h1);
        sup_is(5'h0);
        pwr_up();
        bus(1'b1, CTRL_OFS, 32'h4);
        key <= 1'b0;
        sup_is(5'h0);
        $display("latch done");
        pwr_up();
        stuck <= 1'b1;
        bus(1'b1, CTRL_OFS, 32'h3);
        key <= 1'b0;
        sup_is(5'h0f);
        chk({32'h0, pdr}, 33'h0);
        bus(1'b1, CTRL_OFS, 32'h1);
        sup_is(5'h0);
        $display("stuck relay done");
        // Battery stays present through the stuck path, as with a permanent supply
        perm <= 1'b1;
        key <= 1'b1;
        sup_is(5'h08);
        sup_is(5'h1f);
        key <= 1'b0;
        sup_is(5'h0);
        perm <= 1'b0;
        stuck <= 1'b0;
        $display("permanent supply done");
        bus(1'b1, CFG6_OFS, 32'h1);
        pwr_up();
        bus(1'b1, DRV_OFS, 32'h3f);
        bus(1'b1, CTRL_OFS, 32'h0);
        tick(60);
        key <= 1'b0;
        tick(25);
        chk({27'h0, st, inj}, 33'h3f);
        tick(50);
        chk({22'h0, sup, st, inj}, 33'h7c0);
        $display("shutoff done");
        // Error count of four or more while the key is on withholds the hold delay
        wdf <= 1'b1;
        key <= 1'b1;
        tick(80);
        chk({27'h0, st, inj}, 33'h3f);
        key <= 1'b0;
        tick(25);
        chk({27'h0, st, inj}, 33'h0);
        $display("watchdog fault done");
        wrap_up();
    end
    initial begin
        #200_000;
        error_cnt++;
        wrap_up();
    end
endmodule : key_power_latch_sequencer_test

// ==== key_power_pkg.sv ====
// Constants, register map and carrier types of the key power latch sequencer
package key_power_pkg;
    // Timing, in microseconds, and the oscillator rate
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;
    localparam int unsigned KEY_FILTER_US = 16_000;
    localparam int unsigned REG_DELAY_US  = 1_000;
    localparam int unsigned V3_DELAY_US   = 1_000;
    localparam int unsigned SEO_HOLD_US   = 225_000;
    localparam int unsigned INJ_QUAL_US   = 225_000;
    localparam int unsigned ST_QUAL_US    = 600_000;
    localparam int unsigned LATCH_STEP_US = 100_000;
    localparam int unsigned KEY_FILTER_CYC = KEY_FILTER_US * CYC_PER_US;
    localparam int unsigned REG_DELAY_CYC  = REG_DELAY_US * CYC_PER_US;
    localparam int unsigned V3_DELAY_CYC   = V3_DELAY_US * CYC_PER_US;
    localparam int unsigned SEO_HOLD_CYC   = SEO_HOLD_US * CYC_PER_US;
    localparam int unsigned INJ_QUAL_CYC   = INJ_QUAL_US * CYC_PER_US;
    localparam int unsigned ST_QUAL_CYC    = ST_QUAL_US * CYC_PER_US;
    localparam int unsigned LATCH_STEP_CYC = LATCH_STEP_US * CYC_PER_US;
    localparam int unsigned TMR_W          = 28;
    localparam logic [2:0]  WD_ERR_LIMIT   = 3'h4;

    // Register offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] CFG6_OFS   = 8'h04;
    localparam logic [7:0] DRV_OFS    = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;
    // Field positions
    localparam int unsigned CTRL_LATCH_BIT = 0;
    localparam int unsigned CTRL_HOLD_BIT  = 1;
    localparam int unsigned CTRL_TO_LSB    = 2;
    localparam int unsigned CFG6_SEO_BIT   = 0;
    localparam int unsigned DRV_INJ_LSB    = 0;
    localparam int unsigned DRV_ST_LSB     = 4;
    // Values after reset
    localparam logic [4:0] CTRL_RST = 5'h01;
    localparam logic       CFG6_RST = 1'b0;
    localparam logic [5:0] DRV_RST  = 6'h00;

    typedef enum logic [2:0] {
        ST_OFF   = 3'b000,
        ST_RELAY = 3'b001,
        ST_BIAS  = 3'b011,
        ST_REG5  = 3'b010,
        ST_RUN   = 3'b110,
        ST_HOLD  = 3'b111
    } seq_state_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_type;

    typedef struct packed {
        logic main_relay_drive;
        logic bias;
        logic five_volt_supply;
        logic sensor_supplies;
        logic three_volt_supply;
    } supply_en_type;
endpackage : key_power_pkg

// ==== sat_timer.sv ====
// Saturating interval timer with clear, run and a limit input
`timescale 1ns/10ps
module sat_timer #(
    parameter int unsigned W = 28
) (
    // Clock and reset
    input  wire logic         i_sys_clk,
    input  wire logic         i_sys_rst,
    input  wire logic         i_clk_en,
    // Control
    input  wire logic         i_clear,
    input  wire logic         i_run,
    input  wire logic [W-1:0] i_limit,
    // Status
    output logic              o_done
);
    logic [W-1:0] cnt_ff;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            cnt_ff <= '0;
        end else if (i_clk_en) begin
            if (i_clear) begin
                cnt_ff <= '0;
            end else if (i_run && cnt_ff < i_limit) begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

    assign o_done = (cnt_ff >= i_limit);
endmodule : sat_timer

// ==== supply_model.sv ====
// Supply monitor model driven by the sequencer enables
`timescale 1ns/10ps
module supply_model (
    // Clock
    input  wire logic i_sys_clk,
    // Enables and stuck relay fault
    input  wire logic i_relay,
    input  wire logic i_five_en,
    input  wire logic i_stuck,
    // Monitor levels
    output logic      o_batt_ok,
    output logic      o_five_ok
);
    logic [2:0] bd = '0;
    logic [2:0] fd = '0;
    // Supplies ramp, so monitors lag their enables
    always @(posedge i_sys_clk) begin
        bd <= {bd[1:0], i_relay | i_stuck};
        fd <= {fd[1:0], i_five_en};
    end
    assign o_batt_ok = bd[2];
    assign o_five_ok = fd[2];
endmodule : supply_model
